/* design/lpw_pkg.sv */
// constants, types and register map for the twelve channel led pwm bank
package lpw_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int PWM_STEPS = 256;
  localparam int FAST_HZ = 24_000;
  localparam int SLOW_HZ = 3_600;
  // prescale rounds down, so the real rate sits slightly above nominal
  localparam logic [7:0] PRE_FAST = 8'(CLK_HZ / (FAST_HZ * PWM_STEPS));
  localparam logic [7:0] PRE_SLOW = 8'(CLK_HZ / (SLOW_HZ * PWM_STEPS));
  localparam int NCH = 12;
  localparam logic [7:0] A_SHUTDOWN = 8'h00;
  localparam logic [7:0] A_DUTY0 = 8'h04;
  localparam logic [7:0] A_UPD = 8'h13;
  localparam logic [7:0] A_SCALE0 = 8'h17;
  localparam logic [7:0] A_GEN = 8'h26;
  localparam logic [7:0] A_RATE = 8'h27;
  localparam logic [7:0] A_SRST = 8'h2F;
  localparam logic [7:0] CMD_KEY = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] SCALE_MASK = 6'h3F;
  localparam logic [4:0] DEV_ADDR_HI = 5'h1B;
  localparam int BIT_CTL = 0;
  localparam int SC_ON_BIT = 4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum logic [2:0] {
    LPW_IDLE = 3'h0,
    LPW_ADDR = 3'h1,
    LPW_REG = 3'h2,
    LPW_DATA = 3'h3,
    LPW_ACK = 3'h4
  } lpw_bus_e;
  typedef struct packed {
    logic scl;
    logic sda;
  } lpw_pins_s;
endpackage

/* design/lpw_regs.sv */
// write-only two-wire register bank and shared pwm core, twelve channels
//
// Overview of operation
// - shutdown register bit 0 selects software shutdown or normal; resets to zero.
// - shutdown bit zero turns every output off; register contents are kept.
// - twelve 8-bit duty registers at consecutive addresses, channel order, reset zero.
// - average output equals maximum times duty over 256, binary weighted bits.
// - duty and scale writes go to holding registers, outputs unchanged until update.
// - host writes zero to update register; device copies held values to active.
// - twelve scale registers, 6-bit field in bits 5:0, reset zero.
// - scale codes 10..13 hex select current; codes 00..0F hex turn channel off.
// - global control bit 0 enables channels or shuts all outputs together.
// - rate bit 0 selects 24kHz, 1 selects 3.6kHz, shared by all channels.
// - writing zero to reset register returns all registers, holding included, to default.
// - power-up reset loads defaults into every register, outputs dark.
// - duty value written equals the brightness step produced.
// - register pointer steps by one as each data byte is acknowledged.
// - write transfers only; address 11011 plus two strap bits, direction zero.
`timescale 1ns/10ps
module lpw_regs
  import lpw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [1:0] addr_strap,
  output logic [lpw_pkg::NCH-1:0] led_channel_outputs,
  output logic [lpw_pkg::NCH-1:0][1:0] led_current_sel
);
  import lpw_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  lpw_pins_s pin_s1_r, pin_s2_r, pin_d_r;
  logic [1:0] strap_s1_r, strap_s2_r, strap_r;
  lpw_bus_e st_r, st_nxt, ret_r, ret_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shf_r, shf_nxt, ptr_r, ptr_nxt;
  logic oe_n_r, oe_n_nxt;
  logic sda_out_r;
  logic soft_shutdown_bit_r, gen_r, pwm_rate_bit_r;
  logic [NCH-1:0][7:0] duty_sh_r, duty_act_r;
  logic [NCH-1:0][5:0] scale_sh_r, scale_act_r;
  logic [7:0] pre_cnt_r, pwm_cnt_r;
  logic [NCH-1:0] led_r;
  logic [NCH-1:0][1:0] sel_r;

  // only the second stage of each synchroniser and its one-cycle delayed copy feed logic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
      pin_d_r <= '1;
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end else begin
      pin_s1_r <= '{scl: scl_in, sda: sda_in};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
      strap_s1_r <= addr_strap;
      strap_s2_r <= strap_s1_r;
    end
  end

  wire scl_rise = pin_s2_r.scl & ~pin_d_r.scl;
  wire scl_fall = ~pin_s2_r.scl & pin_d_r.scl;
  wire bus_start = pin_s2_r.scl & pin_d_r.scl & pin_d_r.sda & ~pin_s2_r.sda;
  wire bus_stop = pin_s2_r.scl & pin_d_r.scl & ~pin_d_r.sda & pin_s2_r.sda;
  wire byte_full = (bit_cnt_r == BYTE_BITS);
  wire byte_end = scl_fall & byte_full & ~bus_start & ~bus_stop;
  wire addr_ok = (shf_r == {DEV_ADDR_HI, strap_r, 1'b0});
  wire wr_stb = byte_end & (st_r == LPW_DATA);
  wire upd_stb = wr_stb & hit(ptr_r, A_UPD) & hit(shf_r, CMD_KEY);
  wire srst_stb = wr_stb & hit(ptr_r, A_SRST) & hit(shf_r, RST_BYTE);

  always_comb begin
    st_nxt = st_r;
    ret_nxt = ret_r;
    bit_cnt_nxt = bit_cnt_r;
    shf_nxt = shf_r;
    ptr_nxt = ptr_r;
    oe_n_nxt = oe_n_r;
    if (bus_start) begin
      st_nxt = LPW_ADDR;
      bit_cnt_nxt = '0;
      oe_n_nxt = 1'b1;
    end else if (bus_stop) begin
      st_nxt = LPW_IDLE;
      oe_n_nxt = 1'b1;
    end else begin
      case (st_r)
        LPW_IDLE: begin
          st_nxt = LPW_IDLE;
        end
        LPW_ACK: begin
          if (scl_fall) begin
            st_nxt = ret_r;
            oe_n_nxt = 1'b1;
          end
        end
        LPW_ADDR, LPW_REG, LPW_DATA: begin
          if (scl_rise && !byte_full) begin
            shf_nxt = {shf_r[6:0], pin_s2_r.sda};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (byte_end) begin
            bit_cnt_nxt = '0;
            st_nxt = LPW_ACK;
            oe_n_nxt = 1'b0;
            if (st_r == LPW_ADDR) begin
              ret_nxt = LPW_REG;
              // foreign address or read bit gets no ack
              if (!addr_ok) begin
                st_nxt = LPW_IDLE;
                oe_n_nxt = 1'b1;
              end
            end else if (st_r == LPW_REG) begin
              ret_nxt = LPW_DATA;
              ptr_nxt = shf_r;
            end else begin
              ret_nxt = LPW_DATA;
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        default: begin
          st_nxt = LPW_IDLE;
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= LPW_IDLE;
      ret_r <= LPW_IDLE;
      bit_cnt_r <= '0;
      shf_r <= '0;
      ptr_r <= '0;
      oe_n_r <= 1'b1;
      sda_out_r <= 1'b0;
      strap_r <= '0;
    end else begin
      st_r <= st_nxt;
      ret_r <= ret_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shf_r <= shf_nxt;
      ptr_r <= ptr_nxt;
      oe_n_r <= oe_n_nxt;
      sda_out_r <= 1'b0;
      // strap only follows the pins while no transfer is running
      if (st_r == LPW_IDLE) begin
        strap_r <= strap_s2_r;
      end
    end
  end

  // control bits, global, rate, soft reset, defaults
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_shutdown_bit_r <= 1'b0;
      gen_r <= 1'b0;
      pwm_rate_bit_r <= 1'b0;
    end else if (srst_stb) begin
      soft_shutdown_bit_r <= 1'b0;
      gen_r <= 1'b0;
      pwm_rate_bit_r <= 1'b0;
    end else if (wr_stb) begin
      if (hit(ptr_r, A_SHUTDOWN)) soft_shutdown_bit_r <= shf_r[BIT_CTL];
      if (hit(ptr_r, A_GEN)) gen_r <= shf_r[BIT_CTL];
      if (hit(ptr_r, A_RATE)) pwm_rate_bit_r <= shf_r[BIT_CTL];
    end
  end

  // prescale picks the shared period rate
  wire [7:0] pre_lim = pwm_rate_bit_r ? PRE_SLOW : PRE_FAST;
  // >= so a switch from slow to fast never overruns the new limit
  wire pwm_tick = (pre_cnt_r >= pre_lim - 8'h01);
  // shutdown gate, global bit one forces off
  wire pwm_run = soft_shutdown_bit_r & ~gen_r;

  // one free running period counter for all channels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_r <= '0;
      pwm_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pwm_tick ? 8'h00 : pre_cnt_r + 8'h01;
      if (pwm_tick) pwm_cnt_r <= pwm_cnt_r + 8'h01;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      wire duty_hit = wr_stb & hit(ptr_r, A_DUTY0 + 8'(gi));
      wire scale_hit = wr_stb & hit(ptr_r, A_SCALE0 + 8'(gi));
      // duty holding, scale holding, writes land here only
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          duty_sh_r[gi] <= '0;
          scale_sh_r[gi] <= '0;
        end else if (srst_stb) begin
          duty_sh_r[gi] <= '0;
          scale_sh_r[gi] <= '0;
        end else begin
          if (duty_hit) duty_sh_r[gi] <= shf_r;
          if (scale_hit) scale_sh_r[gi] <= shf_r[5:0] & SCALE_MASK;
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          duty_act_r[gi] <= '0;
          scale_act_r[gi] <= '0;
        end else if (srst_stb) begin
          duty_act_r[gi] <= '0;
          scale_act_r[gi] <= '0;
        end else if (upd_stb) begin
          duty_act_r[gi] <= duty_sh_r[gi];
          scale_act_r[gi] <= scale_sh_r[gi];
        end
      end
      // on for duty of 256 counts, step equals duty, 00xxxx off
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          led_r[gi] <= 1'b0;
          sel_r[gi] <= '0;
        end else begin
          led_r[gi] <= pwm_run & scale_act_r[gi][SC_ON_BIT] &
                       (pwm_cnt_r < duty_act_r[gi]);
          sel_r[gi] <= scale_act_r[gi][1:0];
        end
      end
    end
  endgenerate

  assign sda_out = sda_out_r;
  assign sda_oe_n = oe_n_r;
  assign led_channel_outputs = led_r;
  assign led_current_sel = sel_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_shutdown_dark: assert property (!soft_shutdown_bit_r |=> led_r == '0)
    else $error("output lit in software shutdown");
  a_global_dark: assert property (gen_r |=> led_r == '0)
    else $error("output lit with global off");
  a_shadow_hold: assert property (!upd_stb && !srst_stb |=>
      $stable(duty_act_r) && $stable(scale_act_r))
    else $error("active settings moved without commit");
  a_commit_copy: assert property (upd_stb |=>
      duty_act_r == $past(duty_sh_r) && scale_act_r == $past(scale_sh_r))
    else $error("commit did not copy holding values");
  a_soft_reset: assert property (srst_stb |=>
      !soft_shutdown_bit_r && !gen_r && !pwm_rate_bit_r &&
      duty_sh_r == '0 && scale_sh_r == '0 && duty_act_r == '0 && scale_act_r == '0)
    else $error("soft reset left a register set");
  a_ptr_step: assert property (wr_stb && !bus_start |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer did not step after data byte");
  a_duty_on: assert property (pwm_run && scale_act_r[0][SC_ON_BIT] &&
      pwm_cnt_r < duty_act_r[0] |=> led_r[0])
    else $error("channel dark below its duty");
  a_duty_off: assert property (pwm_cnt_r >= duty_act_r[0] |=> !led_r[0])
    else $error("channel lit at or above its duty");
  a_scale_off: assert property (!scale_act_r[3][SC_ON_BIT] |=> !led_r[3])
    else $error("channel lit with off scale code");
  a_rate_fast: assert property (!pwm_rate_bit_r && !$past(pwm_rate_bit_r) |->
      pre_cnt_r < PRE_FAST)
    else $error("prescale ran past fast limit");
  a_rate_slow: assert property (pwm_rate_bit_r && $past(pwm_rate_bit_r) |->
      pre_cnt_r < PRE_SLOW)
    else $error("prescale ran past slow limit");
  a_addr_nack: assert property (byte_end && st_r == LPW_ADDR && !addr_ok |=>
      oe_n_r && st_r == LPW_IDLE)
    else $error("foreign address acknowledged");
  a_idle_release: assert property (st_r == LPW_IDLE |-> oe_n_r)
    else $error("data line held low while idle");
  a_ack_only: assert property (!oe_n_r |-> st_r == LPW_ACK)
    else $error("data line held low outside an ack");
  a_duty_lands: assert property (wr_stb && hit(ptr_r, A_DUTY0) |=>
      duty_sh_r[0] == $past(shf_r))
    else $error("duty byte missed its holding register");
  a_ctrl_hold: assert property (!wr_stb && !srst_stb |=> $stable(soft_shutdown_bit_r) &&
      $stable(gen_r) && $stable(pwm_rate_bit_r))
    else $error("control bit moved without a write");
  a_period_step: assert property (pwm_tick |=> pwm_cnt_r == $past(pwm_cnt_r) + 8'h01)
    else $error("period counter missed a step");

  c_commit: cover property (upd_stb ##1 led_r != '0);
  c_soft_reset: cover property (srst_stb);
  c_ack_drive: cover property ($fell(oe_n_r) ##[1:400] $rose(oe_n_r));
  c_slow_rate: cover property (pwm_rate_bit_r && pwm_tick);
  c_addr_nack: cover property (byte_end && st_r == LPW_ADDR && !addr_ok);
endmodule // lpw_regs

/* testbench/lpw_host_model.sv */
// two-wire host master model: drives scl, releases sda to the pull-up
`timescale 1ns/10ps
module lpw_host_model (
  input wire logic sys_clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // ten clocks a phase, well above the pin sync delay
  task automatic tick();
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  // start, device byte with write bit, pointer, data
  // several data bytes in one frame, stop early on no ack
  task automatic xfer(input logic [7:0] b[$], output int nack);
    nack = 0;
    sda = 1'b0;
    tick();
    scl = 1'b0;
    foreach (b[k]) begin
      for (int j = 7; j >= 0; j--) begin
        sda = b[k][j];
        tick();
        scl = 1'b1;
        tick();
        scl = 1'b0;
      end
      sda = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      nack = (sda_w !== 1'b0) ? 1 : 0;
      scl = 1'b0;
      if (nack != 0) break;
    end
    sda = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda = 1'b1;
    tick();
  endtask
endmodule // lpw_host_model

/* testbench/lpw_regs_tb_top.sv */
// self-checking bench for the led pwm register bank
`timescale 1ns/10ps
module lpw_regs_tb_top;
  import lpw_pkg::*;
  localparam logic [7:0] DEV = {DEV_ADDR_HI, 2'h2, 1'b0};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr_strap = 2'h2;
  logic scl, sda_host, sda_out, sda_oe_n;
  logic [NCH-1:0] leds;
  logic [NCH-1:0][1:0] sel;
  logic [31:0] cnt [NCH];
  logic [7:0] duty [NCH];
  logic [7:0] dq[$], sq[$];
  // lowest gamma-corrected brightness levels
  logic [7:0] gam [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h0A};
  logic [5:0] ac [NCH] = '{default: 6'h0};
  // two off codes mixed in: 00 and 0F
  logic [5:0] code [NCH] = '{6'h10, 6'h11, 6'h12, 6'h13, 6'h10, 6'h11,
    6'h12, 6'h13, 6'h00, 6'h0F, 6'h12, 6'h10};
  int fails = 0;
  int n_compared = 0;
  int nk;
  // open-drain wire with pull-up
  wire sda_w = sda_host & (sda_oe_n | sda_out);

  lpw_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap(addr_strap),
    .led_channel_outputs(leds), .led_current_sel(sel));
  lpw_host_model i_host (.sys_clk(sys_clk), .sda_w(sda_w), .scl(scl), .sda(sda_host));

  initial forever #4 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] dv, input logic [7:0] p, input logic [7:0] d[$],
      input int exp_nack);
    i_host.xfer({dv, p, d}, nk);
    chk(32'(nk), 32'(exp_nack));
  endtask
  // one whole pwm period gives an exact on-count whatever the phase
  task automatic meas(input int n);
    foreach (cnt[i]) cnt[i] = '0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      foreach (cnt[i]) cnt[i] += 32'(leds[i]);
    end
  endtask
  task automatic chk_all(input int pre);
    foreach (cnt[i]) begin
      chk(cnt[i], ac[i][4] ? 32'(duty[i]) * 32'(pre) : 32'h0);
      chk(32'(sel[i]), 32'(ac[i][1:0]));
    end
  endtask

  // one breathing step: gamma levels shift by sh, channels 6 to 10 move by sh, last channel stays FF
  task automatic load(input int sh);
    dq = {};
    foreach (duty[i]) begin
      duty[i] = (i == NCH - 1) ? 8'hFF : (i < 6) ? gam[(i + sh) % 6] : 8'(i * 23 + sh);
      dq.push_back(duty[i]);
    end
  endtask

  initial begin
    #760_000;
    fails++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk(32'(leds), 32'h0);
    chk(32'(sel), 32'h0);
    chk(32'(sda_oe_n), 32'h1);
    repeat (4) @(posedge sys_clk);
    #1;
    wr({DEV_ADDR_HI, 2'h1, 1'b0}, A_SHUTDOWN, {8'h01}, 1);
    wr({DEV_ADDR_HI, 2'h2, 1'b1}, A_SHUTDOWN, {8'h01}, 1);
    load(0);
    foreach (code[i]) sq.push_back({2'h0, code[i]});
    wr(DEV, A_DUTY0, dq, 0);
    wr(DEV, A_SCALE0, sq, 0);
    wr(DEV, A_SHUTDOWN, {8'h01}, 0);
    wr(DEV, A_UPD, {8'h01}, 0);
    meas(300);
    chk_all(0);
    wr(DEV, A_UPD, {8'h00}, 0);
    ac = code;
    meas(PWM_STEPS * PRE_FAST);
    chk_all(PRE_FAST);
    wr(DEV, A_RATE, {8'h01}, 0);
    meas(300);
    meas(PWM_STEPS * PRE_SLOW);
    chk_all(PRE_SLOW);
    // spills into unmapped pointers, still acked
    wr(DEV, A_RATE, {8'h00, 8'h00, 8'h00}, 0);
    wr(DEV, A_GEN, {8'h01}, 0);
    meas(300);
    chk_all(0);
    wr(DEV, A_GEN, {8'h00}, 0);
    wr(DEV, A_SHUTDOWN, {8'h00}, 0);
    meas(300);
    chk_all(0);
    wr(DEV, A_SHUTDOWN, {8'h01}, 0);
    load(1);
    wr(DEV, A_DUTY0, dq, 0);
    wr(DEV, A_SRST, {8'h5A}, 0);
    wr(DEV, A_UPD, {8'h00}, 0);
    meas(PWM_STEPS * PRE_FAST);
    chk_all(PRE_FAST);
    wr(DEV, A_SRST, {8'h00}, 0);
    wr(DEV, A_SHUTDOWN, {8'h01}, 0);
    wr(DEV, A_UPD, {8'h00}, 0);
    ac = '{default: 6'h0};
    meas(300);
    chk_all(0);
    conclude();
  end
endmodule // lpw_regs_tb_top
